// >>> src/tai_regs.svh
`ifndef TAI_REGS_SVH
`define TAI_REGS_SVH

`define TAI_ADDR_STATUS1      8'h02
`define TAI_ADDR_STATUS2      8'h03
`define TAI_ADDR_OTBEH        8'h3F

`define TAI_S1_ALARM_SPEED    0
`define TAI_S1_FAN_FAULT      1
`define TAI_S1_REMOTE_HIGH    2
`define TAI_S1_REMOTE_LOW     3
`define TAI_S1_REMOTE_OT      4
`define TAI_S1_DIODE_ERR      5
`define TAI_S1_LOCAL_HIGH     6
`define TAI_S1_LOCAL_LOW      7
`define TAI_S2_LOCAL_OT       6
`define TAI_S2_EXT_PULL       7
`define TAI_OTBEH_FAN_EN      7

`define TAI_S1_INT_MASK       8'hDF
`define TAI_S2_INT_MASK       8'hC0
`define TAI_STATUS_RESET      8'h00
`define TAI_FAN_EN_RESET      1'b0
`define TAI_OT_HYST_DEGC      5

`endif

// >>> src/tai_pkg.sv
package tai_pkg;
   typedef logic signed [7:0] tai_temp_t;
   typedef logic [7:0]        tai_byte_t;
   typedef enum logic {
      TAI_CH_LOCAL,
      TAI_CH_REMOTE
   } tai_chan_e;
endpackage

// >>> src/tai_chan_if.sv
`timescale 1ns/10ps
interface tai_chan_if;
   import tai_pkg::*;
   tai_temp_t temp;
   tai_temp_t low_lim;
   tai_temp_t high_lim;
   tai_temp_t ot_lim;
   logic      meas_stb;
   logic      low_viol;
   logic      high_viol;
   logic      ot_active;
   logic      ot_rise;
   modport cmp (input temp, low_lim, high_lim, ot_lim, meas_stb,
                output low_viol, high_viol, ot_active, ot_rise);
   modport ctl (output temp, low_lim, high_lim, ot_lim, meas_stb,
                input low_viol, high_viol, ot_active, ot_rise);
endinterface

// >>> src/tai_limit_cmp.sv
`timescale 1ns/10ps
`include "tai_regs.svh"
module tai_limit_cmp (
   input  wire logic clk_i,
   input  wire logic srst_i,
   tai_chan_if.cmp   ch
);
   import tai_pkg::*;

   logic signed [8:0] release_lvl;
   logic              ot_active_reg;
   logic              ot_rise_reg;

   // Nine bits so that a limit near -128 does not wrap when lowered.
   assign release_lvl  = 9'(ch.ot_lim) - 9'sd`TAI_OT_HYST_DEGC;
   assign ch.low_viol  = ch.temp < ch.low_lim;
   assign ch.high_viol = ch.temp > ch.high_lim;
   assign ch.ot_active = ot_active_reg;
   assign ch.ot_rise   = ot_rise_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ot_active_reg <= 1'b0;
      end else if (ch.meas_stb) begin
         if (ch.temp > ch.ot_lim) begin
            ot_active_reg <= 1'b1;
         end else if (9'(ch.temp) < release_lvl) begin
            ot_active_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ot_rise_reg <= 1'b0;
      end else begin
         ot_rise_reg <= ch.meas_stb & ~ot_active_reg & (ch.temp > ch.ot_lim);
      end
   end
endmodule

// >>> src/tai_pin_sync.sv
`timescale 1ns/10ps
module tai_pin_sync (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic [2:0] stage_reg;
   logic       level_reg;

   assign level_o = level_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stage_reg <= 3'h7;
      end else begin
         stage_reg <= {stage_reg[1:0], pin_i};
      end
   end

   // Only the second and third stages are compared; the first may be metastable.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         level_reg <= 1'b1;
      end else if (stage_reg[1] == stage_reg[2]) begin
         level_reg <= stage_reg[2];
      end
   end
endmodule

// >>> src/tai_alarm_top.sv
`timescale 1ns/10ps
`include "tai_regs.svh"
module tai_alarm_top #(
   // Arbitrary value, not tied to any product.
   parameter logic [3:0] REVISION = 4'h1
) (
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire tai_pkg::tai_temp_t local_temp_i,
   input  wire tai_pkg::tai_temp_t remote_temp_i,
   input  wire tai_pkg::tai_temp_t local_low_lim_i,
   input  wire tai_pkg::tai_temp_t local_high_lim_i,
   input  wire tai_pkg::tai_temp_t local_ot_lim_i,
   input  wire tai_pkg::tai_temp_t remote_low_lim_i,
   input  wire tai_pkg::tai_temp_t remote_high_lim_i,
   input  wire tai_pkg::tai_temp_t remote_ot_lim_i,
   input  wire logic              meas_done_i,
   input  wire logic              local_int_en_i,
   input  wire logic              remote_int_en_i,
   input  wire logic              fan_at_alarm_i,
   input  wire logic              tach_fail_i,
   input  wire logic              diode_err_i,
   input  wire tai_pkg::tai_byte_t reg_addr_i,
   input  wire logic              reg_rd_i,
   input  wire logic              reg_wr_i,
   input  wire tai_pkg::tai_byte_t reg_wdata_i,
   output tai_pkg::tai_byte_t     reg_rdata_o,
   output logic                   alarm_int_n_o,
   input  wire logic              overtemp_line_n_i,
   output logic                   overtemp_line_n_o,
   output logic                   overtemp_line_n_oe_o,
   output logic                   fan_full_speed_o
);
   import tai_pkg::*;

   function automatic logic addr_hit(input tai_byte_t addr, input tai_byte_t target, input logic stb);
      addr_hit = stb & (addr == target);
   endfunction

   tai_chan_if ch_if[2] ();

   tai_temp_t temp_a     [2];
   tai_temp_t low_lim_a  [2];
   tai_temp_t high_lim_a [2];
   tai_temp_t ot_lim_a   [2];
   logic      en_a       [2];
   logic      low_viol_a [2];
   logic      high_viol_a[2];
   logic      ot_act_a   [2];
   logic      ot_rise_a  [2];

   assign temp_a[TAI_CH_LOCAL]      = local_temp_i;
   assign temp_a[TAI_CH_REMOTE]     = remote_temp_i;
   assign low_lim_a[TAI_CH_LOCAL]   = local_low_lim_i;
   assign low_lim_a[TAI_CH_REMOTE]  = remote_low_lim_i;
   assign high_lim_a[TAI_CH_LOCAL]  = local_high_lim_i;
   assign high_lim_a[TAI_CH_REMOTE] = remote_high_lim_i;
   assign ot_lim_a[TAI_CH_LOCAL]    = local_ot_lim_i;
   assign ot_lim_a[TAI_CH_REMOTE]   = remote_ot_lim_i;
   assign en_a[TAI_CH_LOCAL]        = local_int_en_i;
   assign en_a[TAI_CH_REMOTE]       = remote_int_en_i;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         assign ch_if[g].temp     = temp_a[g];
         assign ch_if[g].low_lim  = low_lim_a[g];
         assign ch_if[g].high_lim = high_lim_a[g];
         assign ch_if[g].ot_lim   = ot_lim_a[g];
         assign ch_if[g].meas_stb = meas_done_i;
         assign low_viol_a[g]     = ch_if[g].low_viol;
         assign high_viol_a[g]    = ch_if[g].high_viol;
         assign ot_act_a[g]       = ch_if[g].ot_active;
         assign ot_rise_a[g]      = ch_if[g].ot_rise;

         tai_limit_cmp u_cmp (
            .clk_i  (clk_i),
            .srst_i (srst_i),
            .ch     (ch_if[g])
         );
      end
   endgenerate

   // Pin synchroniser and open-drain drive.
   logic line_level;
   logic self_drive;
   logic ext_low;
   logic ext_low_prev_reg;
   logic [3:0] self_hist_reg;

   tai_pin_sync u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .pin_i   (overtemp_line_n_i),
      .level_o (line_level)
   );

   // The line is never gated by the enable bits, so the fail-safe path survives a masked channel.
   assign self_drive           = ot_act_a[TAI_CH_LOCAL] | ot_act_a[TAI_CH_REMOTE];
   assign overtemp_line_n_o    = 1'b0;
   assign overtemp_line_n_oe_o = self_drive;
   // While this end drives the line its own pull cannot be told apart from an outside one.
   // The synchroniser lags the pin by up to four edges, so the tail of our own pull is masked too.
   assign ext_low              = ~line_level & ~self_drive & ~(|self_hist_reg);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         self_hist_reg <= 4'h0;
      end else begin
         self_hist_reg <= {self_hist_reg[2:0], self_drive};
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ext_low_prev_reg <= 1'b0;
      end else begin
         ext_low_prev_reg <= ext_low;
      end
   end

   // Fan forcing.
   logic fan_force_en_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fan_force_en_reg <= `TAI_FAN_EN_RESET;
      end else if (addr_hit(reg_addr_i, `TAI_ADDR_OTBEH, reg_wr_i)) begin
         fan_force_en_reg <= reg_wdata_i[`TAI_OTBEH_FAN_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fan_full_speed_o <= 1'b0;
      end else begin
         fan_full_speed_o <= (self_drive & fan_force_en_reg) | ext_low;
      end
   end

   // Status flags: a set in the read cycle wins over the clear.
   logic      rd_s1;
   logic      rd_s2;
   logic      fan_alarm_prev_reg;
   logic      first_meas_reg;
   tai_byte_t status1_reg;
   tai_byte_t status2_reg;
   tai_byte_t s1_set;
   tai_byte_t s1_clr;
   tai_byte_t s2_set;
   tai_byte_t s2_clr;

   assign rd_s1 = addr_hit(reg_addr_i, `TAI_ADDR_STATUS1, reg_rd_i);
   assign rd_s2 = addr_hit(reg_addr_i, `TAI_ADDR_STATUS2, reg_rd_i);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fan_alarm_prev_reg <= 1'b0;
      end else begin
         fan_alarm_prev_reg <= fan_at_alarm_i;
      end
   end

   // The diode check belongs to the first conversion after each reset only.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         first_meas_reg <= 1'b1;
      end else if (meas_done_i) begin
         first_meas_reg <= 1'b0;
      end
   end

   always_comb begin
      s1_set = `TAI_STATUS_RESET;
      s1_set[`TAI_S1_ALARM_SPEED] = fan_at_alarm_i & ~fan_alarm_prev_reg;
      s1_set[`TAI_S1_FAN_FAULT]   = tach_fail_i;
      s1_set[`TAI_S1_REMOTE_HIGH] = meas_done_i & en_a[TAI_CH_REMOTE] & high_viol_a[TAI_CH_REMOTE];
      s1_set[`TAI_S1_REMOTE_LOW]  = meas_done_i & en_a[TAI_CH_REMOTE] & low_viol_a[TAI_CH_REMOTE];
      s1_set[`TAI_S1_REMOTE_OT]   = en_a[TAI_CH_REMOTE] & ot_rise_a[TAI_CH_REMOTE];
      s1_set[`TAI_S1_DIODE_ERR]   = meas_done_i & first_meas_reg & diode_err_i;
      s1_set[`TAI_S1_LOCAL_HIGH]  = meas_done_i & en_a[TAI_CH_LOCAL] & high_viol_a[TAI_CH_LOCAL];
      s1_set[`TAI_S1_LOCAL_LOW]   = meas_done_i & en_a[TAI_CH_LOCAL] & low_viol_a[TAI_CH_LOCAL];
   end

   always_comb begin
      s1_clr = rd_s1 ? `TAI_S1_INT_MASK : `TAI_STATUS_RESET;
      s1_clr[`TAI_S1_DIODE_ERR] = 1'b0;
      if (!en_a[TAI_CH_REMOTE]) begin
         s1_clr[`TAI_S1_REMOTE_HIGH] = 1'b1;
         s1_clr[`TAI_S1_REMOTE_LOW]  = 1'b1;
         s1_clr[`TAI_S1_REMOTE_OT]   = 1'b1;
      end
      if (!en_a[TAI_CH_LOCAL]) begin
         s1_clr[`TAI_S1_LOCAL_HIGH] = 1'b1;
         s1_clr[`TAI_S1_LOCAL_LOW]  = 1'b1;
      end
   end

   always_comb begin
      s2_set = `TAI_STATUS_RESET;
      s2_set[`TAI_S2_LOCAL_OT] = en_a[TAI_CH_LOCAL] & ot_rise_a[TAI_CH_LOCAL];
      s2_set[`TAI_S2_EXT_PULL] = ext_low & ~ext_low_prev_reg;
      s2_clr = rd_s2 ? `TAI_S2_INT_MASK : `TAI_STATUS_RESET;
      if (!en_a[TAI_CH_LOCAL]) begin
         s2_clr[`TAI_S2_LOCAL_OT] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         status1_reg <= `TAI_STATUS_RESET;
      end else begin
         status1_reg <= (status1_reg & ~s1_clr) | s1_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         status2_reg <= `TAI_STATUS_RESET;
      end else begin
         status2_reg <= (status2_reg & ~s2_clr) | s2_set;
      end
   end

   // Alarm interrupt line. The diode error cannot be cleared, so it stays out of the OR.
   logic int_pending;

   assign int_pending = |(status1_reg & `TAI_S1_INT_MASK) | |(status2_reg & `TAI_S2_INT_MASK);
   assign alarm_int_n_o = ~int_pending;

   // Read data is the value before any clear of the same read.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `TAI_ADDR_STATUS1: reg_rdata_o <= status1_reg;
            `TAI_ADDR_STATUS2: reg_rdata_o <= status2_reg;
            `TAI_ADDR_OTBEH:   reg_rdata_o <= {fan_force_en_reg, 3'h0, REVISION};
            default:           reg_rdata_o <= 8'h00;
         endcase
      end
   end
endmodule

// >>> testbench/tai_alarm_checker.sv
`timescale 1ns/10ps
module tai_alarm_checker (
   input  wire logic               clk_i,
   input  wire logic               srst_i,
   input  wire tai_pkg::tai_temp_t remote_temp_i,
   input  wire tai_pkg::tai_temp_t remote_low_lim_i,
   input  wire tai_pkg::tai_temp_t remote_high_lim_i,
   input  wire tai_pkg::tai_temp_t remote_ot_lim_i,
   input  wire logic               meas_done_i,
   input  wire logic               remote_int_en_i,
   input  wire tai_pkg::tai_byte_t reg_addr_i,
   input  wire logic               reg_rd_i,
   input  wire tai_pkg::tai_byte_t reg_rdata_o,
   input  wire logic               alarm_int_n_o,
   input  wire logic               overtemp_line_n_i,
   input  wire logic               overtemp_line_n_o,
   input  wire logic               overtemp_line_n_oe_o,
   input  wire logic               fan_full_speed_o
);
   import tai_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_ot_start;
      meas_done_i && remote_temp_i > remote_ot_lim_i && !overtemp_line_n_oe_o;
   endsequence
   sequence s_ext_low;
      (!overtemp_line_n_oe_o && !overtemp_line_n_i) [*6];
   endsequence
   a_od_low_only: assert property (overtemp_line_n_o == 1'b0)
      else $error("overtemp line driven high");
   a_ot_sets_oe: assert property (s_ot_start |=> overtemp_line_n_oe_o)
      else $error("overtemp not asserted");
   a_ot_raises_int: assert property (s_ot_start ##1 remote_int_en_i |=> !alarm_int_n_o)
      else $error("overtemp did not raise alarm");
   a_oe_rise_cause: assert property ($rose(overtemp_line_n_oe_o) |-> $past(meas_done_i))
      else $error("overtemp rose without measurement");
   a_oe_fall_cause: assert property ($fell(overtemp_line_n_oe_o) |-> $past(meas_done_i))
      else $error("overtemp fell without measurement");
   a_high_sets_int: assert property (meas_done_i && remote_int_en_i && remote_temp_i > remote_high_lim_i
      |=> !alarm_int_n_o) else $error("high limit missed");
   a_low_sets_int: assert property (meas_done_i && remote_int_en_i && remote_temp_i < remote_low_lim_i
      |=> !alarm_int_n_o) else $error("low limit missed");
   a_ext_forces_fan: assert property (s_ext_low |=> fan_full_speed_o)
      else $error("fan not forced by external pull");
   a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {8'h02, 8'h03, 8'h3F})
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule

// >>> testbench/tai_host_model.sv
`timescale 1ns/10ps
module tai_host_model (
   input  wire logic oe_i,
   input  wire logic pull_i,
   output logic      line_n_o,
   output logic      throttle_o
);
   // The line has a pull-up, so it is high unless some party pulls it low.
   assign line_n_o   = !(oe_i || pull_i);
   assign throttle_o = !line_n_o;
endmodule

// >>> testbench/tai_alarm_top_tb.sv
`timescale 1ns/10ps
module tai_alarm_top_tb;
   import tai_pkg::*;
   localparam logic [3:0] REV = 4'h3;
   logic clk_i = 0, srst_i = 1, meas_done_i = 0, local_int_en_i = 1, remote_int_en_i = 1;
   logic fan_at_alarm_i = 0, tach_fail_i = 0, diode_err_i = 0, reg_rd_i = 0, reg_wr_i = 0, pull = 0;
   tai_temp_t local_temp_i = 8'h1E, remote_temp_i = 8'h1E, local_low_lim_i = 8'h0A, remote_low_lim_i = 8'h0A;
   tai_temp_t local_high_lim_i = 8'h3C, remote_high_lim_i = 8'h3C, local_ot_lim_i = 8'h50, remote_ot_lim_i = 8'h50;
   tai_byte_t reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic alarm_int_n_o, overtemp_line_n_i, overtemp_line_n_o, overtemp_line_n_oe_o, fan_full_speed_o, throttle;
   int n_errors = 0, compares = 0;
   int bits[6] = '{0, 1, 2, 3, 6, 7};
   tai_alarm_top #(.REVISION(REV)) u_dut (.*);
   tai_host_model u_host (.oe_i(overtemp_line_n_oe_o), .pull_i(pull), .line_n_o(overtemp_line_n_i),
      .throttle_o(throttle));
   always #12.5 clk_i = ~clk_i;
   task chk(input tai_byte_t got, input tai_byte_t exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task meas;
      @(posedge clk_i) meas_done_i <= 1'b1;
      @(posedge clk_i) meas_done_i <= 1'b0;
   endtask
   task rd(input tai_byte_t a, input tai_byte_t exp);
      @(posedge clk_i) begin
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
      end
      @(posedge clk_i) reg_rd_i <= 1'b0;
      @(posedge clk_i);
      #1 chk(reg_rdata_o, exp);
   endtask
   task wr(input tai_byte_t a, input tai_byte_t d);
      @(posedge clk_i) begin
         reg_addr_i <= a;
         reg_wdata_i <= d;
         reg_wr_i <= 1'b1;
      end
      @(posedge clk_i) reg_wr_i <= 1'b0;
   endtask
   task restore;
      @(posedge clk_i) begin
         remote_temp_i <= 8'h1E;
         local_temp_i <= 8'h1E;
         fan_at_alarm_i <= 1'b0;
         remote_int_en_i <= 1'b1;
      end
      meas;
   endtask
   task t_flag(input int b);
      tai_byte_t m;
      m = 8'h01 << b;
      @(posedge clk_i);
      case (b)
         0: fan_at_alarm_i <= 1'b1;
         1: tach_fail_i <= 1'b1;
         2: remote_temp_i <= 8'h3D;
         3: remote_temp_i <= 8'h09;
         6: local_temp_i <= 8'h3D;
         default: local_temp_i <= 8'h09;
      endcase
      @(posedge clk_i) tach_fail_i <= 1'b0;
      meas;
      cyc(1);
      #1 chk(8'(alarm_int_n_o), 8'h00);
      rd(8'h02, m);
      chk(8'(alarm_int_n_o), 8'h01);
      meas;
      rd(8'h02, (b < 2) ? 8'h00 : m);
      restore;
      $display("flag %0d done", b);
   endtask
   task t_ot;
      wr(8'h3F, 8'h80);
      rd(8'h3F, {4'h8, REV});
      @(posedge clk_i) remote_temp_i <= 8'h51;
      meas;
      cyc(2);
      #1 chk({6'h00, overtemp_line_n_oe_o, fan_full_speed_o}, 8'h03);
      chk(8'(throttle), 8'h01);
      chk(8'(alarm_int_n_o), 8'h00);
      rd(8'h02, 8'h14);
      chk({7'h00, alarm_int_n_o}, 8'h01);
      meas;
      rd(8'h02, 8'h04);
      // Exactly limit minus five must still hold the line.
      @(posedge clk_i) remote_temp_i <= 8'h4B;
      meas;
      #1 chk(8'(overtemp_line_n_oe_o), 8'h01);
      @(posedge clk_i) remote_temp_i <= 8'h4A;
      meas;
      #1 chk(8'(overtemp_line_n_oe_o), 8'h00);
      wr(8'h3F, 8'h00);
      @(posedge clk_i) begin
         remote_int_en_i <= 1'b0;
         remote_temp_i <= 8'h51;
         local_temp_i <= 8'h51;
      end
      meas;
      cyc(2);
      #1 chk({6'h00, overtemp_line_n_oe_o, fan_full_speed_o}, 8'h02);
      rd(8'h02, 8'h40);
      rd(8'h03, 8'h40);
      chk(8'(alarm_int_n_o), 8'h01);
      restore;
      $display("overtemp done");
   endtask
   task t_ext;
      @(posedge clk_i) pull <= 1'b1;
      cyc(8);
      #1 chk(8'(fan_full_speed_o), 8'h01);
      @(posedge clk_i) pull <= 1'b0;
      cyc(8);
      rd(8'h03, 8'h80);
      rd(8'h03, 8'h00);
      $display("external pull done");
   endtask
   task t_dis;
      @(posedge clk_i) remote_temp_i <= 8'h3D;
      meas;
      #1 chk(8'(alarm_int_n_o), 8'h00);
      @(posedge clk_i) remote_int_en_i <= 1'b0;
      cyc(1);
      #1 chk(8'(alarm_int_n_o), 8'h01);
      rd(8'h02, 8'h00);
      restore;
      $display("disable done");
   endtask
   task t_diode;
      @(posedge clk_i) begin
         srst_i <= 1'b1;
         diode_err_i <= 1'b1;
      end
      cyc(6);
      @(posedge clk_i) srst_i <= 1'b0;
      meas;
      rd(8'h02, 8'h20);
      rd(8'h02, 8'h20);
      chk(8'(alarm_int_n_o), 8'h01);
      $display("diode done");
   endtask
   task final_report;
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      cyc(5);
      @(posedge clk_i) srst_i <= 1'b0;
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h3F, {4'h0, REV});
      rd(8'h10, 8'h00);
      for (int i = 0; i < 6; i++) t_flag(bits[i]);
      t_ot;
      t_ext;
      t_dis;
      t_diode;
      final_report;
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      cyc(5000);
      n_errors++;
      final_report;
   end
endmodule
bind tai_alarm_top tai_alarm_checker u_chk (.clk_i, .srst_i, .remote_temp_i, .remote_low_lim_i,
   .remote_high_lim_i, .remote_ot_lim_i, .meas_done_i, .remote_int_en_i, .reg_addr_i, .reg_rd_i,
   .reg_rdata_o, .alarm_int_n_o, .overtemp_line_n_i, .overtemp_line_n_o, .overtemp_line_n_oe_o,
   .fan_full_speed_o);
